// File: host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic result_irq_oe, // irq pull
  input wire logic result_irq_out, // irq data
  output logic irq_clear // acknowledge
);
  // ==========
  // pulled-up irq line, acknowledged a few cycles after it falls
  logic irq_line;
  logic [1:0] dly_q;
  assign irq_line = result_irq_oe ? result_irq_out : 1'b1;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dly_q <= 2'h0;
      irq_clear <= 1'b0;
    end else begin
      dly_q <= irq_line ? 2'h0 : dly_q + 2'h1;
      irq_clear <= (dly_q == 2'h2);
    end
  end
endmodule : host_model

// File: ranging_checker.sv
`timescale 1ns/10ps
module ranging_checker (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic shutdown_n, // shutdown pin
  input wire logic [1:0] mode_sel, // mode
  input wire logic start_req, // start
  input wire logic stop_req, // stop
  input wire logic result_irq_out, // irq data
  input wire logic result_irq_oe, // irq pull
  input wire logic bus_enable, // bus allowed
  input wire logic result_valid, // result pulse
  input wire logic [2:0] seq_state // state
);
  // ==========
  // cycles from pin release until soft idle is reached
  logic [15:0] bc_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) bc_q <= 16'h0;
    else bc_q <= (shutdown_n && seq_state <= 3'h1) ? bc_q + 16'h1 : 16'h0;
  end
  // ==========
  // shutdown aborts every check except the shutdown one
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn || !shutdown_n);
  AST_OFF: assert property (disable iff (!resetn) !shutdown_n [*4] |-> seq_state == 3'h0 && !bus_enable)
    else $error("not off");
  AST_OD: assert property (result_irq_out == 1'b0) else $error("irq driven high");
  AST_MODE: assert property (seq_state == 3'h2 && start_req |=>
    seq_state == (($past(mode_sel) == 2'h3) ? 3'h2 : 3'h3)) else $error("bad start");
  AST_RUN: assert property (result_valid && seq_state == 3'h3 |-> ##[1:1000] result_valid)
    else $error("ranging stalled");
  AST_FIN: assert property (seq_state == 3'h3 && !result_valid |=> seq_state == 3'h3 || result_valid)
    else $error("measurement cut");
  AST_WSTOP: assert property (seq_state == 3'h4 && stop_req |=> seq_state == 3'h2)
    else $error("wait not ended");
  AST_IRQ: assert property (result_valid |-> result_irq_oe) else $error("no irq");
  AST_BOOT: assert property (bc_q <= 16'h2ee0) else $error("boot too long");
endmodule : ranging_checker

// File: ranging_mode_sequencer.sv
`timescale 1ns/10ps
// Notes on behaviour
// - low shutdown_n holds device off
// - interrupt only pulls low or releases
// - no bus traffic while hard off
// - three modes: single, continuous, timed
// - single: one measurement, then soft idle
// - continuous: next measurement starts immediately
// - continuous runs until host stops
// - stop in continuous finishes current measurement
// - timed: programmed wait between measurements
// - timed stop: finish measurement, abort wait
// - interrupt on each new result
module ranging_mode_sequencer (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic resetn, // async reset, active low
  input wire logic shutdown_n, // shutdown pin, active low
  input wire logic [1:0] mode_sel, // ranging mode select
  input wire logic start_req, // start pulse from host logic
  input wire logic stop_req, // stop pulse from host logic
  input wire logic [31:0] inter_period, // timed-mode wait in cycles
  input wire logic [31:0] meas_cycles, // measurement length in cycles
  input wire logic irq_clear, // host acknowledges result
  output logic result_irq_out, // interrupt pin output level, always 0
  output logic result_irq_oe, // high while pulling interrupt low
  output logic bus_enable, // serial bus may respond
  output logic ranging_busy, // ranging active
  output logic result_valid, // one-cycle pulse per new result
  output logic [2:0] seq_state // current sequencer state
);
  // ==========================================================
  // shutdown pin synchroniser
  logic shut_n_s;
  sync_2ff u_sync_shut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d_in(shutdown_n),
    .q_out(shut_n_s)
  );

  // ==========================================================
  // state machine
  ranging_pkg::seq_state_type state_q, state_d;
  logic [1:0] mode_q;
  logic stop_pend_q;
  logic [ranging_pkg::CNT_W-1:0] cnt_q;
  logic meas_done;
  logic wait_done;
  logic boot_done;
  logic mode_ok;

  function automatic logic legal_mode(input logic [1:0] m);
    legal_mode = (m == ranging_pkg::MODE_SINGLE) || (m == ranging_pkg::MODE_CONTINUOUS) ||
                 (m == ranging_pkg::MODE_TIMED);
  endfunction : legal_mode

  // serial bus answers only once firmware is up
  function automatic logic bus_allowed(input ranging_pkg::seq_state_type s);
    bus_allowed = (s != ranging_pkg::ST_HARD_OFF) && (s != ranging_pkg::ST_BOOT);
  endfunction : bus_allowed

  function automatic logic ranging_active(input ranging_pkg::seq_state_type s);
    ranging_active = (s == ranging_pkg::ST_MEASURE) || (s == ranging_pkg::ST_WAIT);
  endfunction : ranging_active

  assign mode_ok = legal_mode(mode_sel);
  // boot budget counts from the pin edge, so the synchroniser delay is taken off
  assign boot_done = (cnt_q >= ranging_pkg::BOOT_CYCLES - ranging_pkg::BOOT_LAT_CYCLES - 1);
  // measurement and wait each last exactly their programmed cycle count
  assign meas_done = (cnt_q + ranging_pkg::CNT_ONE >= meas_cycles);
  assign wait_done = (cnt_q + ranging_pkg::CNT_ONE >= inter_period);

  // next state; shutdown overrides every other transition
  always_comb begin
    state_d = state_q;
    case (state_q)
      ranging_pkg::ST_HARD_OFF: begin
        state_d = ranging_pkg::ST_BOOT;
      end
      ranging_pkg::ST_BOOT: begin
        if (boot_done) begin
          state_d = ranging_pkg::ST_SOFT_IDLE;
        end
      end
      ranging_pkg::ST_SOFT_IDLE: begin
        if (start_req && mode_ok) begin
          state_d = ranging_pkg::ST_MEASURE;
        end
      end
      ranging_pkg::ST_MEASURE: begin
        if (meas_done) begin
          if (mode_q == ranging_pkg::MODE_SINGLE) begin
            state_d = ranging_pkg::ST_SOFT_IDLE;
          end else if (stop_pend_q || stop_req) begin
            state_d = ranging_pkg::ST_SOFT_IDLE;
          end else if (mode_q == ranging_pkg::MODE_CONTINUOUS) begin
            state_d = ranging_pkg::ST_MEASURE;
          end else if (inter_period == ranging_pkg::CNT_ZERO) begin
            state_d = ranging_pkg::ST_MEASURE;
          end else begin
            state_d = ranging_pkg::ST_WAIT;
          end
        end
      end
      ranging_pkg::ST_WAIT: begin
        if (stop_req) begin
          state_d = ranging_pkg::ST_SOFT_IDLE;
        end else if (wait_done) begin
          state_d = ranging_pkg::ST_MEASURE;
        end
      end
      default: begin
        state_d = ranging_pkg::ST_HARD_OFF;
      end
    endcase
    if (!shut_n_s) begin
      state_d = ranging_pkg::ST_HARD_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ranging_pkg::ST_HARD_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // cycle counter, restarted on every state entry
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= ranging_pkg::CNT_ZERO;
    end else if (state_d != state_q || (state_q == ranging_pkg::ST_MEASURE && meas_done)) begin
      cnt_q <= ranging_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_q + ranging_pkg::CNT_ONE;
    end
  end

  // mode latched at start
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= ranging_pkg::MODE_RESET;
    end else if (state_q == ranging_pkg::ST_SOFT_IDLE && start_req && mode_ok) begin
      mode_q <= mode_sel;
    end
  end

  // stop remembered until the running measurement ends
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stop_pend_q <= 1'b0;
    end else if (state_q != ranging_pkg::ST_MEASURE) begin
      stop_pend_q <= 1'b0;
    end else if (stop_req) begin
      stop_pend_q <= 1'b1;
    end else if (meas_done) begin
      stop_pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  logic new_result;
  assign new_result = (state_q == ranging_pkg::ST_MEASURE) && meas_done && shut_n_s;

  // one pulse per finished measurement; a cut measurement gives none
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= new_result;
    end
  end

  // pull held until the host acknowledges; a new result beats the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      result_irq_oe <= 1'b0;
    end else if (!shut_n_s) begin
      result_irq_oe <= 1'b0;
    end else if (new_result) begin
      result_irq_oe <= 1'b1; // set wins over clear
    end else if (irq_clear) begin
      result_irq_oe <= 1'b0;
    end
  end

  // open drain: the data level never goes high, only the enable moves
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      result_irq_out <= 1'b0;
    end else begin
      result_irq_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_enable <= 1'b0;
    end else begin
      bus_enable <= bus_allowed(state_d);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ranging_busy <= 1'b0;
    end else begin
      ranging_busy <= ranging_active(state_d);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_state <= 3'h0;
    end else begin
      seq_state <= state_d;
    end
  end
endmodule : ranging_mode_sequencer

// File: ranging_pkg.sv
package ranging_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ = 10000000;
  localparam int unsigned BOOT_MAX_NS = 1200000;
  // longest time rounds down
  localparam int unsigned BOOT_CYCLES = (BOOT_MAX_NS / 1000) * (CLK_FREQ_HZ / 1000000);
  // synchroniser and hard-off exit cycles spent before boot starts
  localparam int unsigned BOOT_LAT_CYCLES = 3;
  localparam int unsigned MEAS_CYCLES_DEF = 16;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned PERIOD_W = 32;
  // ==========================================================
  // mode encoding
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
  localparam logic [1:0] MODE_TIMED = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_HARD_OFF = 3'h0,
    ST_BOOT = 3'h1,
    ST_SOFT_IDLE = 3'h2,
    ST_MEASURE = 3'h3,
    ST_WAIT = 3'h4
  } seq_state_type;
endpackage : ranging_pkg

// File: sync_2ff.sv
`timescale 1ns/10ps
module sync_2ff (
  input wire logic clk_sys, // clock
  input wire logic resetn, // async reset, active low
  input wire logic d_in, // asynchronous level
  output logic q_out // synchronised level
);
  logic meta_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : sync_2ff

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0, resetn = 1'b0, shutdown_n = 1'b1, start_req = 1'b0, stop_req = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic [31:0] inter_period = 32'h6, meas_cycles = 32'h4;
  logic irq_clear, result_irq_out, result_irq_oe, bus_enable, ranging_busy, result_valid;
  logic [2:0] seq_state;
  int mismatches = 0, total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  ranging_mode_sequencer i_dut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .shutdown_n(shutdown_n),
    .mode_sel(mode_sel),
    .start_req(start_req),
    .stop_req(stop_req),
    .inter_period(inter_period),
    .meas_cycles(meas_cycles),
    .irq_clear(irq_clear),
    .result_irq_out(result_irq_out),
    .result_irq_oe(result_irq_oe),
    .bus_enable(bus_enable),
    .ranging_busy(ranging_busy),
    .result_valid(result_valid),
    .seq_state(seq_state)
  );
  host_model i_host (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .result_irq_oe(result_irq_oe),
    .result_irq_out(result_irq_out),
    .irq_clear(irq_clear)
  );
  task chk(input logic [2:0] seen, input logic [2:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // ==========
  // bounded wait for a result pulse or a state
  task wt(input bit rv, input logic [2:0] v);
    for (int i = 0; i < 13000; i++) begin
      @(posedge clk_sys);
      #1;
      if (rv ? result_valid === 1'b1 : seq_state === v) return;
    end
    mismatches++;
    end_of_test();
  endtask : wt
  task go(input logic s, input logic [1:0] m);
    @(posedge clk_sys);
    start_req <= s;
    stop_req <= !s;
    mode_sel <= m;
    @(posedge clk_sys);
    start_req <= 1'b0;
    stop_req <= 1'b0;
    #1;
  endtask : go
  // ==========
  // scenarios
  task t_boot;
    wt(1'b0, 3'h2);
    chk({2'h0, bus_enable}, 3'h1);
    go(1'b0, 2'h0);
    chk(seq_state, 3'h2);
    go(1'b1, 2'h3);
    chk(seq_state, 3'h2);
    $display("boot done");
  endtask : t_boot
  task t_single;
    go(1'b1, 2'h0); // start one measurement in single mode
    chk(seq_state, 3'h3);
    chk({2'h0, ranging_busy}, 3'h1);
    wt(1'b1, 3'h0);
    chk(seq_state, 3'h2);
    chk({2'h0, ranging_busy}, 3'h0);
    chk({2'h0, result_irq_out}, 3'h0);
    chk({2'h0, result_irq_oe}, 3'h1);
    repeat (6) @(posedge clk_sys);
    #1;
    chk({2'h0, result_irq_oe}, 3'h0);
    $display("single done");
  endtask : t_single
  task t_cont;
    go(1'b1, 2'h1);
    repeat (3) wt(1'b1, 3'h0);
    chk(seq_state, 3'h3);
    go(1'b0, 2'h1);
    chk(seq_state, 3'h3);
    wt(1'b1, 3'h0);
    chk(seq_state, 3'h2);
    $display("continuous done");
  endtask : t_cont
  task t_timed;
    go(1'b1, 2'h2);
    wt(1'b0, 3'h4);
    repeat (5) @(posedge clk_sys);
    #1;
    chk(seq_state, 3'h4);
    chk({2'h0, ranging_busy}, 3'h1);
    wt(1'b0, 3'h3);
    wt(1'b0, 3'h4);
    go(1'b0, 2'h2);
    chk(seq_state, 3'h2);
    go(1'b1, 2'h2);
    go(1'b0, 2'h2);
    chk(seq_state, 3'h3);
    wt(1'b1, 3'h0);
    chk(seq_state, 3'h2);
    $display("timed done");
  endtask : t_timed
  task t_off;
    go(1'b1, 2'h1);
    @(posedge clk_sys);
    shutdown_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(seq_state, 3'h0);
    chk({2'h0, bus_enable}, 3'h0);
    @(posedge clk_sys);
    shutdown_n <= 1'b1;
    wt(1'b0, 3'h2);
    $display("shutdown done");
  endtask : t_off
  initial begin
    repeat (8) @(posedge clk_sys);
    chk(seq_state, 3'h0);
    resetn <= 1'b1;
    t_boot();
    t_single();
    t_cont();
    t_timed();
    t_off();
    end_of_test();
  end
endmodule : tb_top
bind ranging_mode_sequencer ranging_checker i_chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .shutdown_n(shutdown_n),
  .mode_sel(mode_sel),
  .start_req(start_req),
  .stop_req(stop_req),
  .result_irq_out(result_irq_out),
  .result_irq_oe(result_irq_oe),
  .bus_enable(bus_enable),
  .result_valid(result_valid),
  .seq_state(seq_state)
);
